// ### rtl/mdm_pkg.sv
package mdm_pkg;
	// ****************************************
	// Register map (byte addresses)
	// ****************************************
	localparam logic [11:0] CFG0_OFS   = 12'h500;
	localparam logic [11:0] CFG1_OFS   = 12'h504;
	localparam logic [11:0] TXD_OFS    = 12'h508;
	localparam logic [11:0] RXD_OFS    = 12'h50c;
	localparam logic [11:0] ISTAT_OFS  = 12'h600;
	localparam logic [11:0] IPEND_OFS  = 12'h610;
	localparam logic [11:0] IEN_OFS    = 12'h620;
	localparam logic [11:0] IACK_OFS   = 12'h630;
	// ****************************************
	// Field positions
	// ****************************************
	localparam int ENABLE_BIT   = 6;
	localparam int DIV_LSB      = 0;
	localparam int DIV_W        = 6;
	localparam int PORT_ADDRESS_FIELD_LSB    = 24;
	localparam int DEVICE_ADDRESS_FIELD_LSB    = 16;
	localparam int OP_LSB       = 14;
	localparam int START_BIT    = 11;
	localparam int READY_BIT    = 7;
	localparam int RX_READY_BIT = 16;
	localparam int DONE_BIT     = 0;
	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [5:0]  DIV_RST   = 6'h00;
	localparam logic [4:0]  ADDR_RST  = 5'h00;
	localparam logic [1:0]  OP_RST    = 2'h0;
	localparam logic [15:0] DATA_RST  = 16'h0000;
	localparam logic        IRQ_RST   = 1'b0;
	// ****************************************
	// Frame layout
	// ****************************************
	localparam logic [5:0] PRE_BITS   = 6'h20;
	localparam logic [5:0] FRAME_BITS = 6'h20;
	localparam logic [1:0] START_CODE = 2'h0;
	localparam logic [1:0] TA_CODE    = 2'h2;
	localparam logic [1:0] OP_READ    = 2'h3;
	localparam logic [1:0] OP_PRD_INC = 2'h2;
	// Master releases the line on a read at the bit index one above this
	localparam logic [5:0] TA_IDX     = 6'h11;
	typedef enum { ST_IDLE, ST_PRE, ST_FRAME, ST_DONE } mdm_state_t;
endpackage

// ### rtl/mdm_master.sv
`timescale 1ns/10ps
// Summary of operation
// - Enable bit gates the start of all PHY accesses
// - Divider field sets MDC period
// - Port address from config bits 28:24
// - Device address from config bits 20:16
// - Opcode from config bits 15:14
// - Start only accepted while ready
// - Start bit self-clears on completion
// - Ready flag high when idle
// - Transmit data low half sent
// - Read data captured into receive register
// - Receive register bit 16 mirrors ready
// - Completion raises interrupt when enabled
// - Interrupt bit 0 is completion only
// - Read data valid before interrupt rises
// - Interrupt holds until acknowledged or disabled
// - Status bit cleared by writing zero
// - Pending is enable and status; W1C
// - Enable register write-one enables, reset zero
// - Acknowledge register write-only, one clears
module mdm_master #(
	parameter int DIV_WIDTH = 6
) (
	input  wire logic        core_clk_i,
	input  wire logic        arst_n_i,
	input  wire logic [11:0] addr_i,
	input  wire logic [31:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [31:0] rdata_o,
	output logic             mdc_o,
	output logic             mdio_o,
	output logic             mdio_oe_o,
	input  wire logic        mdio_i,
	output logic             irq_o
);
	import mdm_pkg::*;

	// ****************************************
	// Elaboration checks
	// ****************************************
	// Divider field must fit below the enable bit
	if (DIV_WIDTH < 1 || DIV_WIDTH > ENABLE_BIT) begin : g_div_chk
		$error("divider width out of range");
	end

	// ****************************************
	// Register state
	// ****************************************
	logic             en_r, en_nxt;
	logic [DIV_WIDTH-1:0] div_r, div_nxt;
	logic [4:0]       prt_r, prt_nxt;
	logic [4:0]       dev_r, dev_nxt;
	logic [1:0]       op_r, op_nxt;
	logic [15:0]      txd_r, txd_nxt;
	logic [15:0]      rxd_r, rxd_nxt;
	logic             ist_r, ist_nxt;
	logic             ien_r, ien_nxt;
	logic [31:0]      rdata_r, rdata_nxt;
	logic             irq_r, irq_nxt;

	// ****************************************
	// Engine state
	// ****************************************
	mdm_state_t       st_r, st_nxt;
	logic [DIV_WIDTH-1:0] cnt_r, cnt_nxt;
	logic             mdc_r, mdc_nxt;
	logic [5:0]       bit_r, bit_nxt;
	logic [31:0]      sh_r, sh_nxt;
	logic             mdio_r, mdio_nxt;
	logic             oe_r, oe_nxt;
	logic             rdop_r, rdop_nxt;

	logic ready;
	logic start_req;
	logic tick;
	logic rise;
	logic fall;

	function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
		hit = (a == ofs);
	endfunction

	assign ready     = (st_r == ST_IDLE);
	assign start_req = wr_i && hit(addr_i, CFG1_OFS) && wdata_i[START_BIT]
	                   && ready && en_r;
	// Half period is divider+1 core cycles
	assign tick      = (cnt_r == div_r);
	assign rise      = tick && !mdc_r;
	assign fall      = tick && mdc_r;

	// ****************************************
	// Register file next state
	// ****************************************
	always_comb begin
		en_nxt  = en_r;
		div_nxt = div_r;
		prt_nxt = prt_r;
		dev_nxt = dev_r;
		op_nxt  = op_r;
		txd_nxt = txd_r;
		ien_nxt = ien_r;
		ist_nxt = ist_r;
		if (wr_i) begin
			if (hit(addr_i, CFG0_OFS)) begin
				en_nxt  = wdata_i[ENABLE_BIT];
				div_nxt = wdata_i[DIV_LSB +: DIV_WIDTH];
			end
			if (hit(addr_i, CFG1_OFS) && ready) begin
				prt_nxt = wdata_i[PORT_ADDRESS_FIELD_LSB +: 5];
				dev_nxt = wdata_i[DEVICE_ADDRESS_FIELD_LSB +: 5];
				op_nxt  = wdata_i[OP_LSB +: 2];
			end
			if (hit(addr_i, TXD_OFS) && ready) begin
				txd_nxt = wdata_i[15:0];
			end
			if (hit(addr_i, IEN_OFS)) begin
				ien_nxt = wdata_i[DONE_BIT];
			end
			if (hit(addr_i, ISTAT_OFS) && !wdata_i[DONE_BIT]) begin
				ist_nxt = 1'b0;
			end
			if ((hit(addr_i, IPEND_OFS) || hit(addr_i, IACK_OFS))
			    && wdata_i[DONE_BIT]) begin
				ist_nxt = 1'b0;
			end
		end
		// Completion beats a same-cycle clear
		if (st_r == ST_DONE) begin
			ist_nxt = 1'b1;
		end
		irq_nxt = ist_nxt && ien_nxt;
	end

	// ****************************************
	// Read mux
	// ****************************************
	always_comb begin
		rdata_nxt = 32'h0000_0000;
		if (rd_i) begin
			case (addr_i)
				CFG0_OFS: begin
					rdata_nxt[ENABLE_BIT]           = en_r;
					rdata_nxt[DIV_LSB +: DIV_WIDTH] = div_r;
				end
				CFG1_OFS: begin
					rdata_nxt[PORT_ADDRESS_FIELD_LSB +: 5] = prt_r;
					rdata_nxt[DEVICE_ADDRESS_FIELD_LSB +: 5] = dev_r;
					rdata_nxt[OP_LSB +: 2]    = op_r;
					rdata_nxt[START_BIT]      = !ready;
					rdata_nxt[READY_BIT]      = ready;
				end
				TXD_OFS: rdata_nxt[15:0] = txd_r;
				RXD_OFS: begin
					rdata_nxt[15:0]         = rxd_r;
					rdata_nxt[RX_READY_BIT] = ready;
				end
				ISTAT_OFS: rdata_nxt[DONE_BIT] = ist_r;
				IPEND_OFS: rdata_nxt[DONE_BIT] = ist_r && ien_r;
				IEN_OFS:   rdata_nxt[DONE_BIT] = ien_r;
				default:   rdata_nxt = 32'h0000_0000;
			endcase
		end
	end

	// ****************************************
	// Frame engine next state
	// ****************************************
	always_comb begin
		st_nxt   = st_r;
		cnt_nxt  = tick ? '0 : cnt_r + 1'b1;
		mdc_nxt  = tick ? !mdc_r : mdc_r;
		bit_nxt  = bit_r;
		sh_nxt   = sh_r;
		mdio_nxt = mdio_r;
		oe_nxt   = oe_r;
		rdop_nxt = rdop_r;
		rxd_nxt  = rxd_r;
		case (st_r)
			ST_IDLE: begin
				// Clock parked low, line released while idle
				cnt_nxt  = '0;
				mdc_nxt  = 1'b0;
				oe_nxt   = 1'b0;
				mdio_nxt = 1'b1;
				if (start_req) begin
					st_nxt   = ST_PRE;
					bit_nxt  = PRE_BITS;
					// Fields written with the start bit apply to this frame
					rdop_nxt = (wdata_i[OP_LSB +: 2] == OP_READ)
					           || (wdata_i[OP_LSB +: 2] == OP_PRD_INC);
					sh_nxt   = {START_CODE, wdata_i[OP_LSB +: 2], wdata_i[PORT_ADDRESS_FIELD_LSB +: 5],
					            wdata_i[DEVICE_ADDRESS_FIELD_LSB +: 5], TA_CODE, txd_r};
				end
			end
			ST_PRE: begin
				if (fall) begin
					oe_nxt   = 1'b1;
					mdio_nxt = 1'b1;
					bit_nxt  = bit_r - 1'b1;
					if (bit_r == 6'h01) begin
						st_nxt  = ST_FRAME;
						bit_nxt = FRAME_BITS;
					end
				end
			end
			ST_FRAME: begin
				// Launch on falling edge so the PHY samples on rising
				if (fall) begin
					if (bit_r == 6'h00) begin
						st_nxt = ST_DONE;
						oe_nxt = 1'b0;
					end else begin
						mdio_nxt = sh_r[31];
						sh_nxt   = {sh_r[30:0], 1'b0};
						bit_nxt  = bit_r - 1'b1;
						if (rdop_r && bit_r <= TA_IDX + 6'h01) begin
							oe_nxt = 1'b0;
						end
					end
				end
				if (rise && rdop_r && bit_r < 6'h10) begin
					rxd_nxt = {rxd_r[14:0], mdio_i};
				end
			end
			ST_DONE: begin
				st_nxt = ST_IDLE;
			end
			default: st_nxt = ST_IDLE;
		endcase
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			en_r    <= 1'b0;
			div_r   <= DIV_RST[DIV_WIDTH-1:0];
			prt_r   <= ADDR_RST;
			dev_r   <= ADDR_RST;
			op_r    <= OP_RST;
			txd_r   <= DATA_RST;
			rxd_r   <= DATA_RST;
			ist_r   <= IRQ_RST;
			ien_r   <= IRQ_RST;
			rdata_r <= 32'h0000_0000;
			irq_r   <= 1'b0;
			st_r    <= ST_IDLE;
			cnt_r   <= '0;
			mdc_r   <= 1'b0;
			bit_r   <= 6'h00;
			sh_r    <= 32'h0000_0000;
			mdio_r  <= 1'b1;
			oe_r    <= 1'b0;
			rdop_r  <= 1'b0;
		end else begin
			en_r    <= en_nxt;
			div_r   <= div_nxt;
			prt_r   <= prt_nxt;
			dev_r   <= dev_nxt;
			op_r    <= op_nxt;
			txd_r   <= txd_nxt;
			rxd_r   <= rxd_nxt;
			ist_r   <= ist_nxt;
			ien_r   <= ien_nxt;
			rdata_r <= rdata_nxt;
			irq_r   <= irq_nxt;
			st_r    <= st_nxt;
			cnt_r   <= cnt_nxt;
			mdc_r   <= mdc_nxt;
			bit_r   <= bit_nxt;
			sh_r    <= sh_nxt;
			mdio_r  <= mdio_nxt;
			oe_r    <= oe_nxt;
			rdop_r  <= rdop_nxt;
		end
	end

	assign rdata_o   = rdata_r;
	assign mdc_o     = mdc_r;
	assign mdio_o    = mdio_r;
	assign mdio_oe_o = oe_r;
	assign irq_o     = irq_r;
endmodule // mdm_master

// ### bench/mdm_phy.sv
`timescale 1ns/10ps
// ****
// Far-side management device
// ****
module mdm_phy (
	input  wire logic        mdc_i,
	input  wire logic        oe_i,
	input  wire logic        line_i,
	input  wire logic [15:0] data_i,
	output logic             line_o,
	output logic      [63:0] frame_o
);
	int cnt = 0;
	initial line_o = 1'b1;
	initial frame_o = 64'h0;
	always @(posedge oe_i) cnt = 0;
	// Last 64 rising edges hold the frame
	always @(posedge mdc_i) begin
		frame_o = {frame_o[62:0], line_i};
		cnt = cnt + 1;
	end
	// Pull-up level except a zero at count 47 and the data bits at counts 48 to 63
	always @(negedge mdc_i)
		line_o = (cnt == 47) ? 1'b0 : (cnt > 47 && cnt < 64) ? data_i[63 - cnt] : 1'b1;
endmodule // mdm_phy

// ### bench/mdm_master_asserts.sv
`timescale 1ns/10ps
module mdm_chk (
	input  wire logic        core_clk_i,
	input  wire logic        arst_n_i,
	input  wire logic [11:0] addr_i,
	input  wire logic [31:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	input  wire logic [31:0] rdata_o,
	input  wire logic        mdc_o,
	input  wire logic        mdio_o,
	input  wire logic        mdio_oe_o,
	input  wire logic        irq_o
);
	import mdm_pkg::*;
	logic en_r;
	logic clr;
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!arst_n_i);
	always_ff @(posedge core_clk_i or negedge arst_n_i)
		if (!arst_n_i) en_r <= 1'b0;
		else if (wr_i && addr_i == CFG0_OFS) en_r <= wdata_i[ENABLE_BIT];
	assign clr = wr_i && (((addr_i == IACK_OFS || addr_i == IPEND_OFS) && wdata_i[0])
		|| ((addr_i == ISTAT_OFS || addr_i == IEN_OFS) && !wdata_i[0]));
	// Bench runs the divider at 1: two cycles each half
	sequence s_hi2; mdc_o [*2]; endsequence
	property p_div; $rose(mdc_o) |-> s_hi2 ##1 !mdc_o; endproperty
	property p_en; !en_r |-> !mdio_oe_o && !mdc_o; endproperty
	property p_pre; $rose(mdio_oe_o) |-> mdio_o; endproperty
	property p_edge; mdio_oe_o && $changed(mdio_o) |-> !mdc_o; endproperty
	property p_isr; $past(rd_i && addr_i[11:8] == 4'h6) |-> rdata_o[31:1] == 31'h0; endproperty
	property p_ack; $past(rd_i && addr_i == IACK_OFS) |-> rdata_o == 32'h0; endproperty
	property p_start;
		$past(rd_i && addr_i == CFG1_OFS) |-> rdata_o[START_BIT] != rdata_o[READY_BIT];
	endproperty
	property p_hold; $fell(irq_o) |-> $past(clr) || $past(clr, 2); endproperty
	a_div: assert property (p_div) else $error("mdc half period wrong");
	a_en: assert property (p_en) else $error("line active while disabled");
	a_pre: assert property (p_pre) else $error("preamble not one");
	a_edge: assert property (p_edge) else $error("mdio moved off falling mdc");
	a_isr: assert property (p_isr) else $error("reserved irq bits set");
	a_ack: assert property (p_ack) else $error("ack reg readable");
	a_start: assert property (p_start) else $error("start and ready agree");
	a_hold: assert property (p_hold) else $error("irq dropped unasked");
endmodule // mdm_chk
bind mdm_master mdm_chk u_mdm_chk (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i),
	.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
	.mdc_o(mdc_o), .mdio_o(mdio_o), .mdio_oe_o(mdio_oe_o), .irq_o(irq_o));

// ### bench/test_mdm_master.sv
`timescale 1ns/10ps
module test_mdm_master;
	import mdm_pkg::*;
	logic        clk = 1'b0;
	logic        arst_n = 1'b0;
	logic [11:0] addr = 12'h0;
	logic [31:0] wdata = 32'h0;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [31:0] rdata;
	logic        mdc, mdio, oe, line, phy_line, irq;
	logic [15:0] pdat = 16'h0;
	logic [63:0] frame;
	int          n_errors = 0;
	int          compares = 0;
	always #5 clk = ~clk;
	// Released line falls back to the device's level
	assign line = oe ? mdio : phy_line;
	mdm_master u_mdm_master (.core_clk_i(clk), .arst_n_i(arst_n), .addr_i(addr),
		.wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .mdc_o(mdc),
		.mdio_o(mdio), .mdio_oe_o(oe), .mdio_i(line), .irq_o(irq));
	mdm_phy u_mdm_phy (.mdc_i(mdc), .oe_i(oe), .line_i(line), .data_i(pdat),
		.line_o(phy_line), .frame_o(frame));
	task automatic wrap_up;
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic cmp(input string nm, input logic [63:0] e, input logic [63:0] g);
		compares++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic wr32(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rdc(input logic [11:0] a, input logic [31:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 cmp($sformatf("reg %h", a), {32'h0, e}, {32'h0, rdata});
	endtask
	initial begin
		logic [31:0] f;
		int          op;
		int          i;
		repeat (5) @(posedge clk);
		arst_n <= 1'b1;
		rdc(CFG1_OFS, 32'h80);
		rdc(RXD_OFS, 32'h10000);
		rdc(ISTAT_OFS, 32'h0);
		rdc(IPEND_OFS, 32'h0);
		rdc(IEN_OFS, 32'h0);
		rdc(IACK_OFS, 32'h0);
		rdc(12'h7fc, 32'h0);
		wr32(CFG1_OFS, 32'h800);
		rdc(CFG1_OFS, 32'h80);
		wr32(CFG0_OFS, 32'h41);
		wr32(IEN_OFS, 32'h1);
		rdc(IEN_OFS, 32'h1);
		for (op = 0; op < 4; op++) begin
			f = {3'h0, 5'(op * 7 + 3), 3'h0, 5'(op * 5 + 1), 2'(op), 14'h0};
			pdat <= 16'h3c5a + 16'(op);
			wr32(TXD_OFS, 32'hc3a5 ^ op);
			wr32(CFG1_OFS, f | 32'h800);
			rdc(CFG1_OFS, f | 32'h800);
			wr32(TXD_OFS, 32'hffff);
			for (i = 0; i < 1000 && irq !== 1'b1; i++) @(posedge clk);
			if (i == 1000) begin
				n_errors++;
				wrap_up;
			end
			if (op > 1) rdc(RXD_OFS, {16'h1, pdat});
			cmp("frame", {32'hffffffff, 2'h0, f[15:14], f[28:24], f[20:16], 2'h2,
				op > 1 ? pdat : 16'hc3a5 ^ 16'(op)}, frame);
			rdc(CFG1_OFS, f | 32'h80);
			rdc(ISTAT_OFS, 32'h1);
			rdc(IPEND_OFS, 32'h1);
			case (op)
				0: wr32(IACK_OFS, 32'h1);
				1: wr32(IPEND_OFS, 32'h1);
				2: wr32(ISTAT_OFS, 32'h0);
				default: wr32(IEN_OFS, 32'h0);
			endcase
			repeat (3) @(posedge clk);
			cmp("irq", 64'h0, 64'(irq));
			rdc(IPEND_OFS, 32'h0);
			rdc(ISTAT_OFS, 32'(op == 3));
		end
		wrap_up;
	end
endmodule // test_mdm_master
